// ---- arc_top.sv ----
// converter result path: interrupt, offset-cal input short, compensation
//
// Overview of operation
// R1: interrupt request on every conversion completion
// R2: disabled converter blocks new requests, keeps pending
// R3: thirty calibration bytes, three per mode
// R4: offset calibration code shorts differential inputs
// R5: result is corrected plus corrected times gain/65536
// R6: raw result is thirteen-bit two's complement
// R7: raw word: sign on top, overflow lowest; here the overflow bit sits at bit 2, with two zero bits below it
// R8: offset byte sign-extended, shifted left three
// R9: magnitudes multiplied unsigned, sign restored later
// R10: differential mode picks gain by sign
// R11: product rounded by 0x8000, low bytes dropped
// R12: factor negated when signs differ
// R13: factor added to offset-corrected value
// R14: sum shifted right with step-one sign
// R15: overflow bit equals sign when in range
// R16: users scale uncompensated results by 8/7
// R17: small inputs need the unbuffered mode
// R18: differential code 1111 selects offset calibration
// R19: raw result fills high byte, low 7:3
// R20: compensated word valid pulse after fixed latency; here COMP_VALID_OUT is a FIFO level held until COMP_READY_IN takes the word
`timescale 1ns/1ps
`default_nettype none
module arc_top
    import arc_pkg::*;
(
    input  wire logic                     MCLK_IN,
    input  wire logic                     SRST_IN,
    input  wire logic                     ADC_ENABLE_IN,
    input  wire logic                     DIFF_MODE_IN,
    input  wire logic [MODE_W:0]          INPUT_MODE_IN,
    input  wire logic [SEL_W-1:0]         INPUT_SELECT_FIELD_IN,
    input  wire logic                     CONV_DONE_IN,
    input  wire logic [RAW_BITS-1:0]      RAW_RESULT_IN,
    input  wire logic                     RAW_OVF_IN,
    input  wire logic                     IRQ_ACK_IN,
    input  wire logic                     CAL_WR_IN,
    input  wire logic [CAL_AW-1:0]        CAL_ADDR_IN,
    input  wire logic [BYTE_W-1:0]        CAL_DATA_IN,
    input  wire logic                     COMP_READY_IN,
    output logic                          IRQ_OUT,
    output logic                          SHORT_INPUTS_OUT,
    output logic [BYTE_W-1:0]             RESULT_HIGH_BYTE_OUT,
    output logic [BYTE_W-1:0]             RESULT_LOW_BYTE_OUT,
    output logic                          COMP_VALID_OUT,
    output logic [RAW_W-1:0]              COMP_DATA_OUT,
    output logic                          BUSY_OUT
);
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    arc_state_t          state_q;
    logic [RAW_W-1:0]    raw_q;
    logic [RAW_W-1:0]    corr_q;
    logic                corr_neg_q;
    logic [RAW_W-1:0]    mag_q;
    logic [GAIN_W-1:0]   gain_q;
    logic [PROD_W-1:0]   prod_q;
    logic [RAW_W-1:0]    comp_d;
    logic                irq_q;
    logic                short_q;
    logic [OFFS_W-1:0]   offset_byte;
    logic [GAIN_W-1:0]   gain_word;
    logic [RAW_W-1:0]    offset_al;
    logic [RAW_W-1:0]    corr_d;
    logic                gain_neg;
    logic [GAIN_W-1:0]   gain_mag;
    logic [PROD_W-1:0]   rounded;
    logic [RAW_W-1:0]    factor;
    logic [RAW_W-1:0]    sum;
    logic                fifo_ready;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [RAW_W-1:0] abs16(input logic [RAW_W-1:0] v);
        abs16 = v[RAW_W-1] ? RAW_W'(~v + 1'b1) : v;
    endfunction

    // ----------------------------------------------------------------
    // interrupt request
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            irq_q <= 1'b0;
        end else if (CONV_DONE_IN && ADC_ENABLE_IN) begin
            irq_q <= 1'b1; // [R1] [R2]
        end else if (IRQ_ACK_IN) begin
            irq_q <= 1'b0;
        end
    end
    assign IRQ_OUT = irq_q;

    // ----------------------------------------------------------------
    // offset calibration input short
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            short_q <= 1'b0;
        end else begin
            short_q <= DIFF_MODE_IN && (INPUT_SELECT_FIELD_IN == SEL_OFFSET_CAL); // [R4] [R18]
        end
    end
    assign SHORT_INPUTS_OUT = short_q;

    // ----------------------------------------------------------------
    // raw result capture
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            raw_q <= RAW_RESET;
        end else if (CONV_DONE_IN && ADC_ENABLE_IN && state_q == ST_IDLE) begin
            raw_q <= {RAW_RESULT_IN, RAW_OVF_IN, 2'b00}; // [R6] [R7] [R19]
        end
    end
    assign RESULT_HIGH_BYTE_OUT = raw_q[RAW_W-1 -: BYTE_W];
    assign RESULT_LOW_BYTE_OUT  = raw_q[BYTE_W-1:0];

    // ----------------------------------------------------------------
    // calibration store
    // ----------------------------------------------------------------
    arc_calstore u_cal (
        .clk_in     (MCLK_IN),
        .wr_en_in   (CAL_WR_IN), // [R3]
        .wr_addr_in (CAL_ADDR_IN),
        .wr_data_in (CAL_DATA_IN),
        .mode_in    (INPUT_MODE_IN),
        .neg_in     (corr_neg_q),
        .diff_in    (DIFF_MODE_IN), // [R10]
        .offset_out (offset_byte),
        .gain_out   (gain_word)
    );

    // ----------------------------------------------------------------
    // compensation datapath
    // ----------------------------------------------------------------
    always_comb begin
        // data bits of the raw word sit above the overflow bit
        offset_al = RAW_W'({{(RAW_W-OFFS_W){offset_byte[OFFS_W-1]}}, offset_byte}
                    << OFFS_SHIFT); // [R8]
        corr_d    = RAW_W'(raw_q - offset_al); // [R5]
        gain_neg  = gain_q[GAIN_W-1];
        gain_mag  = abs16(gain_q); // [R9]
        rounded   = PROD_W'(prod_q + ROUND_CONST); // [R11]
        factor    = rounded[PROD_W-1:SCALE_SHIFT];
        if (corr_neg_q != gain_neg) begin
            factor = RAW_W'(~factor + 1'b1); // [R12]
        end
        sum       = RAW_W'(corr_q + factor); // [R13]
        comp_d    = {corr_neg_q, sum[RAW_W-1:1]}; // [R14] [R15]
    end

    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (CONV_DONE_IN && ADC_ENABLE_IN) begin
                        state_q <= ST_OFFSET; // [R20]
                    end
                end
                ST_OFFSET: state_q <= ST_MULT;
                ST_MULT:   state_q <= ST_FINISH;
                ST_FINISH: state_q <= ST_PUSH;
                ST_PUSH: begin
                    if (fifo_ready) begin
                        state_q <= ST_IDLE;
                    end
                end
                default:   state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            corr_q     <= '0;
            corr_neg_q <= 1'b0;
            mag_q      <= '0;
        end else if (state_q == ST_OFFSET) begin
            corr_q     <= corr_d;
            corr_neg_q <= corr_d[RAW_W-1];
            mag_q      <= abs16(corr_d); // [R9]
        end
    end

    // gain word is looked up after the corrected sign is known
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            gain_q <= '0;
            prod_q <= '0;
        end else begin
            if (state_q == ST_MULT) begin
                gain_q <= gain_word; // [R10]
            end
            if (state_q == ST_FINISH) begin
                prod_q <= PROD_W'(mag_q) * PROD_W'(gain_mag); // [R9] [R5]
            end
        end
    end

    // ----------------------------------------------------------------
    // output buffer
    // ----------------------------------------------------------------
    arc_fifo #(
        .WIDTH (RAW_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk_in        (MCLK_IN),
        .srst_in       (SRST_IN),
        .in_valid_in   (state_q == ST_PUSH),
        .in_ready_out  (fifo_ready),
        .in_data_in    (comp_d),
        .out_valid_out (COMP_VALID_OUT),
        .out_ready_in  (COMP_READY_IN),
        .out_data_out  (COMP_DATA_OUT)
    );

    assign BUSY_OUT = (state_q != ST_IDLE);
endmodule
`default_nettype wire

// ---- arc_pkg.sv ----
// constants and types shared by the result compensation block
package arc_pkg;
    // ----------------------------------------------------------------
    // data formats
    // ----------------------------------------------------------------
    localparam int RAW_W       = 16;
    localparam int RAW_BITS    = 13;
    localparam int RAW_LSB     = 3;
    localparam int OFFS_W      = 8;
    localparam int OFFS_SHIFT  = 3;
    localparam int GAIN_W      = 16;
    localparam int PROD_W      = 32;
    localparam int SCALE_SHIFT = 16;
    localparam int BYTE_W      = 8;
    localparam int SEL_W       = 4;
    localparam int MODE_W      = 3;
    localparam int NUM_MODES   = 10;
    localparam int CAL_BYTES   = 30;
    localparam int BYTES_PER_MODE = 3;
    localparam int CAL_AW      = 5;
    localparam int FIFO_DEPTH  = 8;
    localparam int FIFO_AW     = 3;

    localparam logic [PROD_W-1:0] ROUND_CONST = 32'h0000_8000;
    localparam logic [SEL_W-1:0]  SEL_OFFSET_CAL = 4'hF;
    localparam logic [RAW_W-1:0]  RAW_RESET   = 16'h0000;

    // per-mode calibration layout: offset, gain high, gain low
    localparam logic [1:0] CAL_OFFS_IDX = 2'h0;
    localparam logic [1:0] CAL_GHI_IDX  = 2'h1;
    localparam logic [1:0] CAL_GLO_IDX  = 2'h2;

    // ----------------------------------------------------------------
    // pipeline states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_OFFSET = 3'b001,
        ST_MULT   = 3'b011,
        ST_FINISH = 3'b010,
        ST_PUSH   = 3'b110
    } arc_state_t;
endpackage

// ---- arc_fifo.sv ----
// small synchronous FIFO between the datapath and the result consumer
`timescale 1ns/1ps
`default_nettype none
module arc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic             clk_in,
    input  wire logic             srst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // room for one more word until the count reaches the full depth
    assign in_ready_out  = (cnt_q < (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_q != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop  = out_valid_out && out_ready_in;
    assign out_data_out = mem[rd_q];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ---- arc_calstore.sv ----
// calibration byte store: offset byte and gain word per input mode
`timescale 1ns/1ps
`default_nettype none
module arc_calstore
    import arc_pkg::*;
(
    input  wire logic                  clk_in,
    input  wire logic                  wr_en_in,
    input  wire logic [CAL_AW-1:0]     wr_addr_in,
    input  wire logic [BYTE_W-1:0]     wr_data_in,
    input  wire logic [MODE_W:0]       mode_in,
    input  wire logic                  neg_in,
    input  wire logic                  diff_in,
    output logic      [OFFS_W-1:0]     offset_out,
    output logic      [GAIN_W-1:0]     gain_out
);
    // 30 bytes, three per mode
    logic [BYTE_W-1:0] mem [CAL_BYTES];
    logic [MODE_W:0]   gmode;
    logic [CAL_AW-1:0] base;
    logic [CAL_AW-1:0] gbase;

    always_ff @(posedge clk_in) begin
        if (wr_en_in && (wr_addr_in < CAL_AW'(CAL_BYTES))) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    // differential negative values use the next mode's gain word, except in mode 9 and above, which keep their own
    always_comb begin
        gmode = (diff_in && neg_in && (mode_in < (MODE_W+1)'(NUM_MODES-1))) ?
                mode_in + 1'b1 : mode_in;
        base  = CAL_AW'(mode_in) * CAL_AW'(BYTES_PER_MODE);
        gbase = CAL_AW'(gmode) * CAL_AW'(BYTES_PER_MODE);
        offset_out = mem[base + CAL_AW'(CAL_OFFS_IDX)];
        gain_out   = {mem[gbase + CAL_AW'(CAL_GHI_IDX)], mem[gbase + CAL_AW'(CAL_GLO_IDX)]};
    end
endmodule
`default_nettype wire

// ---- arc_top_sva.sv ----
// property checker for the result compensation block
`timescale 1ns/1ps
`default_nettype none
module arc_top_sva
    import arc_pkg::*;
(
    input wire logic                MCLK_IN,
    input wire logic                SRST_IN,
    input wire logic                ADC_ENABLE_IN,
    input wire logic                DIFF_MODE_IN,
    input wire logic [SEL_W-1:0]    INPUT_SELECT_FIELD_IN,
    input wire logic                CONV_DONE_IN,
    input wire logic [RAW_BITS-1:0] RAW_RESULT_IN,
    input wire logic                RAW_OVF_IN,
    input wire logic                IRQ_ACK_IN,
    input wire logic                COMP_READY_IN,
    input wire logic                IRQ_OUT,
    input wire logic                SHORT_INPUTS_OUT,
    input wire logic [BYTE_W-1:0]   RESULT_HIGH_BYTE_OUT,
    input wire logic [BYTE_W-1:0]   RESULT_LOW_BYTE_OUT,
    input wire logic                COMP_VALID_OUT,
    input wire logic [RAW_W-1:0]    COMP_DATA_OUT,
    input wire logic                BUSY_OUT
);
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (SRST_IN);
    wire logic take = CONV_DONE_IN && ADC_ENABLE_IN && !BUSY_OUT;

    irq_set_a: assert property (CONV_DONE_IN && ADC_ENABLE_IN |=> IRQ_OUT)
        else $error("completion raised no interrupt");
    irq_quiet_a: assert property (!ADC_ENABLE_IN && !IRQ_OUT |=> !IRQ_OUT)
        else $error("interrupt raised while disabled");
    irq_hold_a: assert property (IRQ_OUT && !IRQ_ACK_IN |=> IRQ_OUT)
        else $error("pending interrupt lost");
    short_sel_a: assert property (1'b1 |=> SHORT_INPUTS_OUT ==
        $past(DIFF_MODE_IN && INPUT_SELECT_FIELD_IN == SEL_OFFSET_CAL))
        else $error("input short does not follow selection");
    raw_word_a: assert property (take |=>
        {RESULT_HIGH_BYTE_OUT, RESULT_LOW_BYTE_OUT} ==
        {$past(RAW_RESULT_IN), $past(RAW_OVF_IN), 2'b00})
        else $error("raw word layout wrong");
    comp_lat_a: assert property (take |-> ##5 COMP_VALID_OUT)
        else $error("compensated word late");
    busy_run_a: assert property (take |=> BUSY_OUT [*3])
        else $error("busy dropped early");
    fifo_hold_a: assert property (COMP_VALID_OUT && !COMP_READY_IN |=>
        COMP_VALID_OUT && $stable(COMP_DATA_OUT))
        else $error("head word changed while stalled");

    cover property (take);
    cover property (IRQ_OUT && !ADC_ENABLE_IN);
    cover property (COMP_VALID_OUT && COMP_DATA_OUT[15] != COMP_DATA_OUT[14]);
endmodule
bind arc_top arc_top_sva chk_u (
    .MCLK_IN               (MCLK_IN),
    .SRST_IN               (SRST_IN),
    .ADC_ENABLE_IN         (ADC_ENABLE_IN),
    .DIFF_MODE_IN          (DIFF_MODE_IN),
    .INPUT_SELECT_FIELD_IN (INPUT_SELECT_FIELD_IN),
    .CONV_DONE_IN          (CONV_DONE_IN),
    .RAW_RESULT_IN         (RAW_RESULT_IN),
    .RAW_OVF_IN            (RAW_OVF_IN),
    .IRQ_ACK_IN            (IRQ_ACK_IN),
    .COMP_READY_IN         (COMP_READY_IN),
    .IRQ_OUT               (IRQ_OUT),
    .SHORT_INPUTS_OUT      (SHORT_INPUTS_OUT),
    .RESULT_HIGH_BYTE_OUT  (RESULT_HIGH_BYTE_OUT),
    .RESULT_LOW_BYTE_OUT   (RESULT_LOW_BYTE_OUT),
    .COMP_VALID_OUT        (COMP_VALID_OUT),
    .COMP_DATA_OUT         (COMP_DATA_OUT),
    .BUSY_OUT              (BUSY_OUT)
);
`default_nettype wire

// ---- arc_far_model.sv ----
// stand-in for the conversion engine and the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module arc_far_model (
    input  wire logic        clk_in,
    input  wire logic        irq_in,
    input  wire logic        ack_en_in,
    input  wire logic        req_in,
    input  wire logic [12:0] req_raw_in,
    input  wire logic        req_ovf_in,
    output logic             done_out = 1'b0,
    output logic      [12:0] raw_out = 13'h0000,
    output logic             ovf_out = 1'b0,
    output logic             ack_out = 1'b0
);
    // result lines carry a value only in the completion cycle
    always @(posedge clk_in) begin
        done_out <= req_in;
        raw_out  <= req_in ? req_raw_in : ~raw_out;
        ovf_out  <= req_in ? req_ovf_in : ~ovf_out;
        ack_out  <= ack_en_in && irq_in && !ack_out;
    end
endmodule
`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the result compensation block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import arc_pkg::*;
    logic                MCLK_IN;
    logic                SRST_IN = 1'b1;
    logic                ADC_ENABLE_IN = 1'b1;
    logic                DIFF_MODE_IN = 1'b0;
    logic [MODE_W:0]     INPUT_MODE_IN = 4'h0;
    logic [SEL_W-1:0]    INPUT_SELECT_FIELD_IN = 4'h0;
    logic                CAL_WR_IN = 1'b0;
    logic [CAL_AW-1:0]   CAL_ADDR_IN = 5'h00;
    logic [BYTE_W-1:0]   CAL_DATA_IN = 8'h00;
    logic                COMP_READY_IN = 1'b1;
    logic                CONV_DONE_IN, RAW_OVF_IN, IRQ_ACK_IN, IRQ_OUT;
    logic [RAW_BITS-1:0] RAW_RESULT_IN;
    logic                SHORT_INPUTS_OUT, COMP_VALID_OUT, BUSY_OUT;
    logic [BYTE_W-1:0]   RESULT_HIGH_BYTE_OUT, RESULT_LOW_BYTE_OUT;
    logic [RAW_W-1:0]    COMP_DATA_OUT;
    logic                req = 1'b0;
    logic                req_ovf = 1'b0;
    logic                ack_en = 1'b1;
    logic [12:0]         req_raw = 13'h0000;
    int                  miscompares = 0;
    int                  checks_done = 0;

    arc_top dut_u (
        .MCLK_IN               (MCLK_IN),
        .SRST_IN               (SRST_IN),
        .ADC_ENABLE_IN         (ADC_ENABLE_IN),
        .DIFF_MODE_IN          (DIFF_MODE_IN),
        .INPUT_MODE_IN         (INPUT_MODE_IN),
        .INPUT_SELECT_FIELD_IN (INPUT_SELECT_FIELD_IN),
        .CONV_DONE_IN          (CONV_DONE_IN),
        .RAW_RESULT_IN         (RAW_RESULT_IN),
        .RAW_OVF_IN            (RAW_OVF_IN),
        .IRQ_ACK_IN            (IRQ_ACK_IN),
        .CAL_WR_IN             (CAL_WR_IN),
        .CAL_ADDR_IN           (CAL_ADDR_IN),
        .CAL_DATA_IN           (CAL_DATA_IN),
        .COMP_READY_IN         (COMP_READY_IN),
        .IRQ_OUT               (IRQ_OUT),
        .SHORT_INPUTS_OUT      (SHORT_INPUTS_OUT),
        .RESULT_HIGH_BYTE_OUT  (RESULT_HIGH_BYTE_OUT),
        .RESULT_LOW_BYTE_OUT   (RESULT_LOW_BYTE_OUT),
        .COMP_VALID_OUT        (COMP_VALID_OUT),
        .COMP_DATA_OUT         (COMP_DATA_OUT),
        .BUSY_OUT              (BUSY_OUT)
    );
    arc_far_model far_u (.clk_in(MCLK_IN), .irq_in(IRQ_OUT), .ack_en_in(ack_en),
        .req_in(req), .req_raw_in(req_raw), .req_ovf_in(req_ovf), .done_out(CONV_DONE_IN),
        .raw_out(RAW_RESULT_IN), .ovf_out(RAW_OVF_IN), .ack_out(IRQ_ACK_IN));

    initial begin
        MCLK_IN = 1'b0;
        forever #5 MCLK_IN = ~MCLK_IN;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge MCLK_IN);
        #1;
    endtask

    // expected compensated word, worked out step by step
    function automatic logic [15:0] comp(input logic [12:0] r, input logic [7:0] o,
        input logic [15:0] gp, input logic [15:0] gn, input logic df);
        logic [15:0] v, a, g, ag, f;
        logic [31:0] p;
        logic        s;
        v = {r, 3'h0} - {{5{o[7]}}, o, 3'h0};
        s = v[15];
        g = (df && s) ? gn : gp;
        a = s ? -v : v;
        ag = g[15] ? -g : g;
        p = a * ag + ROUND_CONST;
        f = (s ^ g[15]) ? -p[31:16] : p[31:16];
        v = v + f;
        return {s, v[15:1]};
    endfunction

    task automatic wcal(input logic [3:0] m, input logic [7:0] o, input logic [15:0] g);
        logic [7:0] b [3];
        b = '{o, g[15:8], g[7:0]};
        for (int i = 0; i < 3; i++) begin
            CAL_WR_IN = 1'b1;
            CAL_ADDR_IN = 5'(m * 3 + i);
            CAL_DATA_IN = b[i];
            cyc(1);
        end
        CAL_WR_IN = 1'b0;
        // let an edge pass with the write strobe low; the store takes a byte on every edge it is high
        cyc(1);
    endtask

    task automatic fire(input logic [12:0] r, input logic o);
        int n = 0;
        while (BUSY_OUT !== 1'b0 && n < 50) begin
            cyc(1);
            n++;
        end
        req = 1'b1;
        req_raw = r;
        req_ovf = o;
        cyc(1);
        req = 1'b0;
        cyc(2);
    endtask

    task automatic grab(output logic [15:0] d);
        int n = 0;
        while (COMP_VALID_OUT !== 1'b1 && n < 50) begin
            cyc(1);
            n++;
        end
        d = COMP_DATA_OUT;
        cyc(1);
    endtask

    task automatic t_comp();
        logic [15:0] d, e;
        logic [12:0] rv [6];
        rv = '{13'h0100, 13'h1F00, 13'h0003, 13'h1FFF, 13'h0F00, 13'h1100};
        for (int k = 0; k < 12; k++) begin
            DIFF_MODE_IN = k[0];
            INPUT_MODE_IN = k[0] ? 4'h2 : 4'h0;
            fire(rv[k/2], 1'b0);
            grab(d);
            e = comp(rv[k/2], 8'h05, 16'h1000, 16'h1000, 1'b0);
            if (k[0]) e = comp(rv[k/2], 8'hFB, 16'hF000, 16'h0800, 1'b1);
            chk(d, e);
            chk(16'(d[15] ^ d[14]), 16'h0000);
            chk({RESULT_HIGH_BYTE_OUT, RESULT_LOW_BYTE_OUT}, {rv[k/2], 3'h0});
        end
        DIFF_MODE_IN = 1'b0;
        INPUT_MODE_IN = 4'h0;
        fire(13'h0FFF, 1'b0);
        grab(d);
        chk(d, comp(13'h0FFF, 8'h05, 16'h1000, 16'h1000, 1'b0));
        chk(16'(d[15] ^ d[14]), 16'h0001);
        fire(13'h0ACE, 1'b1);
        grab(d);
        chk({RESULT_HIGH_BYTE_OUT, RESULT_LOW_BYTE_OUT}, {13'h0ACE, 3'h4});
    endtask

    task automatic t_irq();
        ack_en = 1'b0;
        fire(13'h0010, 1'b0);
        chk(16'(IRQ_OUT), 16'h0001);
        ADC_ENABLE_IN = 1'b0;
        cyc(10);
        chk(16'(IRQ_OUT), 16'h0001);
        ack_en = 1'b1;
        cyc(3);
        ack_en = 1'b0;
        fire(13'h0020, 1'b0);
        cyc(10);
        chk(16'(IRQ_OUT), 16'h0000);
        chk(16'(COMP_VALID_OUT), 16'h0000);
        ADC_ENABLE_IN = 1'b1;
        ack_en = 1'b1;
        cyc(3);
    endtask

    task automatic t_short();
        for (int i = 0; i < 32; i++) begin
            DIFF_MODE_IN = i[4];
            INPUT_SELECT_FIELD_IN = i[3:0];
            cyc(2);
            chk(16'(SHORT_INPUTS_OUT), 16'(i == 31));
        end
        DIFF_MODE_IN = 1'b0;
    endtask

    task automatic t_fifo();
        logic [15:0] d;
        COMP_READY_IN = 1'b0;
        for (int i = 0; i < 9; i++) fire(13'(i * 64), 1'b0);
        cyc(10);
        chk(16'(BUSY_OUT), 16'h0001);
        COMP_READY_IN = 1'b1;
        for (int i = 0; i < 9; i++) begin
            grab(d);
            chk(d, comp(13'(i * 64), 8'h05, 16'h1000, 16'h1000, 1'b0));
        end
        chk(16'(COMP_VALID_OUT), 16'h0000);
    endtask

    initial begin
        #200000;
        miscompares++;
        summarize();
    end

    initial begin
        cyc(8);
        SRST_IN = 1'b0;
        wcal(4'h0, 8'h05, 16'h1000);
        wcal(4'h2, 8'hFB, 16'hF000);
        wcal(4'h3, 8'h11, 16'h0800);
        t_comp();
        t_irq();
        t_short();
        t_fifo();
        summarize();
    end
endmodule
`default_nettype wire
